// file: hw/sfcc_map.vh
// Constants of the serial memory command core: opcodes, status layout,
// protect ranges and array size.
// Assumes inclusion by bare name from the design files.
`ifndef SFCC_MAP_VH
`define SFCC_MAP_VH

// ***********************
// Command opcodes
// ***********************
`define SFCC_OP_LATCH_SET 8'h06
`define SFCC_OP_LATCH_CLEAR 8'h04
`define SFCC_OP_STATUS_READ 8'h05
`define SFCC_OP_STATUS_WRITE 8'h01
`define SFCC_OP_MEM_READ 8'h03
`define SFCC_OP_MEM_WRITE 8'h02
`define SFCC_OP_LATENCY_READ 8'h0b

// ***********************
// Status register layout
// ***********************
`define SFCC_ST_PIN_GUARD 7
`define SFCC_ST_GUARD_HI 3
`define SFCC_ST_GUARD_LO 2
`define SFCC_ST_WRITE_LATCH 1
`define SFCC_ST_RESET 8'h00

// ***********************
// Array and protect ranges
// ***********************
`define SFCC_AW 14
`define SFCC_DEPTH 16384
`define SFCC_ADDR_LAST 14'h3fff
`define SFCC_ADDR_ZERO 14'h0000
`define SFCC_PROT_QUARTER 14'h3000
`define SFCC_PROT_HALF 14'h2000
`define SFCC_PROT_ALL 14'h0000

`endif

// file: hw/sfcc_pin_sync.v
// Two-stage synchroniser for one asynchronous input level.
// Assumes the input is unrelated to sys_clk_i.
`timescale 1ns/1ns
module sfcc_pin_sync #(
    // Reset level, set to the idle level of the pin
    parameter [0:0] RST_VAL = 1'b1
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire pin_i,
    output wire sync_o
);
    reg meta_q;
    reg sync_q;

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // sfcc_pin_sync

// file: hw/sfcc_guard_store.v
// Nonvolatile-style holding of the two block guard bits.
// Assumes the cell is never reset, standing in for nonvolatile storage.
`timescale 1ns/1ns
`include "sfcc_map.vh"
module sfcc_guard_store (
    input wire sys_clk_i,
    input wire wr_i,
    input wire [1:0] guard_i,
    output wire [1:0] guard_o
);
    // Backing cell kept outside reset so values survive power loss
    reg [1:0] cell_q;

    initial cell_q = 2'h0;

    always @(posedge sys_clk_i) begin
        if (wr_i) begin
            cell_q <= guard_i; // R11
        end
    end

    assign guard_o = cell_q;
endmodule // sfcc_guard_store

// file: hw/sfcc_core.v
// Command core of a serial ferroelectric memory acting as SPI slave.
// Assumes SPI mode 0 or 3 with link clock much slower than sys_clk_i.
// How it works
// R1 - Latch set 06h, latch clear 04h opcodes
// R2 - Status read 05h, status write 01h
// R3 - Memory read 03h, memory write 02h
// R4 - Write latch clear after reset
// R5 - Latch set command sets latch, status bit1
// R6 - Status writes never touch the latch; the code clears it at select rise after a status write
// R7 - Latch cleared at select rise after writes
// R8 - Latch clear command clears write latch
// R9 - Status bits: 7 pin guard, 3-2 guards, 1 latch
// R10 - Bits 0,4-6 unwritable, read zero
// R11 - Guard bits kept nonvolatile; the code keeps only bits 3-2 and clears pin guard bit 7 at reset
// R12 - Guard code decodes protected upper range
// R13 - Array write needs latch, unprotected address
// R14 - Protect pin low blocks status write if enabled
// R15 - Status read returns one status byte
// R16 - Status write updates guard bits only
// R17 - Two address bytes, low 14 bits used
// R18 - Write stores bytes, increments with wrap
// R19 - Each byte committed after its last bit
// R20 - Protected address stops burst until deselect
// R21 - Read streams bytes, ignores input, wraps
// R22 - Select rise ends read, releases output
// R23 - Fast read 0Bh has dummy byte latency
// R24 - Fast read streams, ignores input, tristates
// R25 - First byte per select is the command
`timescale 1ns/1ns
`include "sfcc_map.vh"
module sfcc_core (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    input wire wp_n_i,
    output reg so_o,
    output reg so_oe_o,
    output wire [7:0] status_o
);
    // ***********************
    // States
    // ***********************
    localparam [5:0] ST_CMD = 6'b000001;
    localparam [5:0] ST_ADDR = 6'b000010;
    localparam [5:0] ST_DUMMY = 6'b000100;
    localparam [5:0] ST_WDATA = 6'b001000;
    localparam [5:0] ST_RDATA = 6'b010000;
    localparam [5:0] ST_IDLE = 6'b100000;

    // Guard decode of an address
    function prot_hit;
        input [1:0] guard;
        input [13:0] addr;
        begin
            case (guard)
                2'b01: prot_hit = (addr >= `SFCC_PROT_QUARTER); // R12
                2'b10: prot_hit = (addr >= `SFCC_PROT_HALF); // R12
                2'b11: prot_hit = (addr >= `SFCC_PROT_ALL); // R12
                default: prot_hit = 1'b0; // R12
            endcase
        end
    endfunction

    // ***********************
    // Pin synchronisers
    // ***********************
    wire cs_n_s;
    wire sck_s;
    wire si_s;
    wire wp_n_s;

    sfcc_pin_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i(cs_n_i),
        .sync_o(cs_n_s)
    );
    sfcc_pin_sync #(.RST_VAL(1'b0)) u_sync_sck (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i(sck_i),
        .sync_o(sck_s)
    );
    sfcc_pin_sync #(.RST_VAL(1'b0)) u_sync_si (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i(si_i),
        .sync_o(si_s)
    );
    sfcc_pin_sync #(.RST_VAL(1'b1)) u_sync_wp (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i(wp_n_i),
        .sync_o(wp_n_s)
    );

    // ***********************
    // Edge detection
    // ***********************
    reg cs_n_q;
    reg sck_q;
    reg mode3_q;
    reg armed_q;

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            cs_n_q <= cs_n_s;
            sck_q <= sck_s;
        end
    end

    wire cs_fall = cs_n_q & ~cs_n_s;
    wire cs_rise = ~cs_n_q & cs_n_s;
    wire sck_rise = ~sck_q & sck_s & ~cs_n_s & armed_q;
    wire sck_fall = sck_q & ~sck_s & ~cs_n_s;

    // ***********************
    // Status, latch and array
    // ***********************
    reg latch_q;
    reg pin_guard_q;
    wire [1:0] guard;
    reg guard_wr;
    reg [7:0] mem [0:`SFCC_DEPTH-1];

    assign status_o = {pin_guard_q, 3'b000, guard, latch_q, 1'b0}; // R9 R10

    // ***********************
    // Shift machine
    // ***********************
    reg [5:0] state_q;
    reg [7:0] opcode_q;
    reg [7:0] shin_q;
    reg [2:0] bit_q;
    reg addr_hi_q;
    reg [13:0] addr_q;
    reg [7:0] shout_q;
    reg stopped_q;
    reg did_write_q;
    reg [7:0] byte_in;
    reg [7:0] rd_byte;

    // Byte as it stands once this bit is in
    always @* begin
        byte_in = {shin_q[6:0], si_s};
        rd_byte = mem[addr_q];
    end

    sfcc_guard_store u_guard (
        .sys_clk_i(sys_clk_i),
        .wr_i(guard_wr),
        .guard_i(byte_in[`SFCC_ST_GUARD_HI:`SFCC_ST_GUARD_LO]),
        .guard_o(guard)
    );

    // Pin low blocks status writes only while its enable is set
    wire pin_block = pin_guard_q & ~wp_n_s; // R14
    // Last bit of a byte arrives on this clock
    wire byte_done = sck_rise & (bit_q == 3'd7);

    always @* begin
        guard_wr = 1'b0;
        if (byte_done && (state_q == ST_WDATA)
            && (opcode_q == `SFCC_OP_STATUS_WRITE) && latch_q && !did_write_q
            && !pin_block) begin
            guard_wr = 1'b1; // R14 R16
        end
    end

    // Array commit on the eighth bit, no page buffer
    always @(posedge sys_clk_i) begin
        if (byte_done && (state_q == ST_WDATA)
            && (opcode_q == `SFCC_OP_MEM_WRITE) && latch_q && !stopped_q
            && !prot_hit(guard, addr_q)) begin
            mem[addr_q] <= byte_in; // R13 R19
        end
    end

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            opcode_q <= 8'h00;
            shin_q <= 8'h00;
            bit_q <= 3'd0;
            addr_hi_q <= 1'b1;
            addr_q <= `SFCC_ADDR_ZERO;
            shout_q <= 8'h00;
            stopped_q <= 1'b0;
            did_write_q <= 1'b0;
            latch_q <= 1'b0; // R4
            pin_guard_q <= 1'b0;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            mode3_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (cs_rise) begin
            // Latch commands and write-ending clears act here
            if (state_q != ST_CMD && state_q != ST_IDLE
                && (opcode_q == `SFCC_OP_STATUS_WRITE
                || opcode_q == `SFCC_OP_MEM_WRITE)) begin
                latch_q <= 1'b0; // R7
            end
            if (state_q == ST_IDLE && opcode_q == `SFCC_OP_LATCH_CLEAR) begin
                latch_q <= 1'b0; // R7 R8
            end
            if (state_q == ST_IDLE && opcode_q == `SFCC_OP_LATCH_SET) begin
                latch_q <= 1'b1; // R5
            end
            state_q <= ST_IDLE;
            so_oe_o <= 1'b0; // R22 R24
            opcode_q <= 8'h00;
        end else if (cs_fall) begin
            state_q <= ST_CMD; // R25
            bit_q <= 3'd0;
            addr_hi_q <= 1'b1;
            stopped_q <= 1'b0;
            did_write_q <= 1'b0;
            opcode_q <= 8'h00;
            mode3_q <= sck_s;
            armed_q <= ~sck_s;
        end else begin
            // Mode 3: first rise counts once the clock has been low
            if (mode3_q && !armed_q && !sck_s && !cs_n_s) begin
                armed_q <= 1'b1;
            end
            if (sck_fall && state_q == ST_RDATA) begin
                so_oe_o <= 1'b1;
                so_o <= shout_q[7]; // R21 R24
                shout_q <= {shout_q[6:0], 1'b0};
            end
            if (sck_rise) begin
                shin_q <= byte_in;
                bit_q <= bit_q + 3'd1;
                if (bit_q == 3'd7) begin
                    case (state_q)
                        ST_CMD: begin
                            opcode_q <= byte_in; // R25
                            case (byte_in)
                                `SFCC_OP_STATUS_READ: begin
                                    state_q <= ST_RDATA; // R2
                                    shout_q <= status_o; // R15
                                end
                                `SFCC_OP_STATUS_WRITE: state_q <= ST_WDATA; // R2
                                `SFCC_OP_MEM_READ: state_q <= ST_ADDR; // R3
                                `SFCC_OP_MEM_WRITE: state_q <= ST_ADDR; // R3
                                `SFCC_OP_LATENCY_READ: state_q <= ST_ADDR; // R23
                                default: state_q <= ST_IDLE; // R1
                            endcase
                        end
                        ST_ADDR: begin
                            addr_hi_q <= 1'b0;
                            if (addr_hi_q) begin
                                addr_q[13:8] <= byte_in[5:0]; // R17
                            end else begin
                                addr_q[7:0] <= byte_in; // R17
                                if (opcode_q == `SFCC_OP_MEM_WRITE) begin
                                    state_q <= ST_WDATA;
                                end else if (opcode_q == `SFCC_OP_LATENCY_READ) begin
                                    state_q <= ST_DUMMY; // R23
                                end else begin
                                    state_q <= ST_RDATA;
                                    shout_q <= mem[{addr_q[13:8], byte_in}];
                                end
                            end
                        end
                        ST_DUMMY: begin
                            state_q <= ST_RDATA; // R23
                            shout_q <= rd_byte;
                        end
                        ST_WDATA: begin
                            if (opcode_q == `SFCC_OP_STATUS_WRITE) begin
                                if (guard_wr) begin
                                    pin_guard_q <= byte_in[`SFCC_ST_PIN_GUARD]; // R6 R16
                                end
                                did_write_q <= 1'b1;
                            end else if (!stopped_q) begin
                                if (!latch_q || prot_hit(guard, addr_q)) begin
                                    stopped_q <= 1'b1; // R20
                                end else begin
                                    addr_q <= addr_q + 14'd1; // R18
                                end
                            end
                        end
                        ST_RDATA: begin
                            if (opcode_q == `SFCC_OP_STATUS_READ) begin
                                shout_q <= 8'h00; // R15
                            end else begin
                                addr_q <= addr_q + 14'd1; // R21
                                shout_q <= mem[addr_q + 14'd1]; // R21
                            end
                        end
                        default: state_q <= ST_IDLE;
                    endcase
                end
            end
        end
    end
endmodule // sfcc_core

// file: tb/sfcc_core_sva.sv
// Port checker for the serial memory command core.
// Assumes a bind onto sfcc_core from the bench top.
`timescale 1ns/1ns
module sfcc_core_sva (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    input wire wp_n_i,
    input wire so_o,
    input wire so_oe_o,
    input wire [7:0] status_o
);
    wire [2:0] guard = {status_o[7], status_o[3:2]};
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_RSV_ZERO: assert property (status_o[6:4] == 3'h0 && !status_o[0])
        else $error("reserved status bits set");
    AST_RESET_LATCH: assert property ($rose(nrst_i) |-> !status_o[1])
        else $error("latch set after reset");
    AST_LATCH_AT_RISE: assert property ($changed(status_o[1]) |-> $past(cs_n_i) && $past(cs_n_i, 2))
        else $error("latch moved while selected");
    AST_GUARD_NEEDS_LATCH: assert property ($changed(guard) |-> $past(status_o[1]))
        else $error("status written without latch");
    AST_PIN_BLOCKS: assert property ($changed(guard) |-> !$past(status_o[7]) || $past(wp_n_i))
        else $error("status written with pin low");
    AST_SO_ON_FALL: assert property ($changed(so_o) && so_oe_o && $past(so_oe_o) && !cs_n_i |-> !sck_i)
        else $error("data out moved while clock high");
    AST_OE_IN_FRAME: assert property ($rose(so_oe_o) |-> !cs_n_i && !$past(cs_n_i, 8))
        else $error("output driven outside a frame");
    AST_OE_RELEASE: assert property ($rose(cs_n_i) |-> ##[1:5] !so_oe_o)
        else $error("output not released");
    cover property ($rose(so_oe_o));
    cover property ($rose(status_o[1]));
    cover property ($changed(guard));
endmodule // sfcc_core_sva

// file: tb/sfcc_spim.sv
// SPI master model, mode 0 or 3, half period of four system clocks.
// Assumes the bench calls its tasks at falling system clock edges.
`timescale 1ns/1ns
module sfcc_spim (
    input wire sys_clk_i,
    input wire so_i,
    input wire so_oe_i,
    output reg cs_n_o,
    output reg sck_o,
    output reg si_o
);
    reg last_q = 1'b0;
    reg mode3_q = 1'b0;
    wire miso = so_oe_i ? so_i : ~last_q;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    always @(posedge sys_clk_i) begin
        if (so_oe_i) begin
            last_q <= so_i;
        end
    end
    task hp(input integer n);
        repeat (4 * n) @(negedge sys_clk_i);
    endtask
    task sel(input m3);
        mode3_q = m3;
        sck_o = m3;
        hp(1);
        cs_n_o = 1'b0;
        hp(1);
    endtask
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            sck_o = 1'b0;
            si_o = tx[i];
            hp(1);
            sck_o = 1'b1;
            rx = {rx[6:0], miso};
            hp(1);
        end
    endtask
    task desel;
        sck_o = mode3_q;
        hp(1);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        hp(2);
    endtask
endmodule // sfcc_spim

// file: tb/tb_sfcc_core.sv
// Self-checking bench for the serial memory command core.
// Assumes the design, checker and master model are compiled first.
`timescale 1ns/1ns
module tb_sfcc_core;
    reg sys_clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg wp_n_i = 1'b1;
    wire cs_n_i, sck_i, si_i, so_o, so_oe_o;
    wire [7:0] status_o;
    integer err_total = 0;
    integer checks_done = 0;
    integer cycles = 0;
    reg [7:0] rx;
    always #20 sys_clk_i = ~sys_clk_i;
    sfcc_core i_sfcc_core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
        .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
        .status_o(status_o));
    sfcc_spim i_sfcc_spim (.sys_clk_i(sys_clk_i), .so_i(so_o), .so_oe_i(so_oe_o),
        .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i));
    task chk(input [7:0] seen, input [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            err_total = err_total + 1;
            give_verdict;
        end
    end
    task op1(input [7:0] op);
        i_sfcc_spim.sel(1'b0);
        i_sfcc_spim.xfer(op, rx);
        i_sfcc_spim.desel;
    endtask
    task sread(input [7:0] exp);
        i_sfcc_spim.sel(1'b0);
        i_sfcc_spim.xfer(8'h05, rx);
        i_sfcc_spim.xfer(8'h00, rx);
        i_sfcc_spim.desel;
        chk(rx, exp);
        chk(status_o, exp);
    endtask
    task swr(input [7:0] d, input wp);
        op1(8'h06);
        wp_n_i = wp;
        i_sfcc_spim.sel(1'b0);
        i_sfcc_spim.xfer(8'h01, rx);
        i_sfcc_spim.xfer(d, rx);
        i_sfcc_spim.desel;
        wp_n_i = 1'b1;
    endtask
    task wrm(input [15:0] a, input [31:0] d, input integer n);
        integer i;
        i_sfcc_spim.sel(1'b0);
        i_sfcc_spim.xfer(8'h02, rx);
        i_sfcc_spim.xfer(a[15:8], rx);
        i_sfcc_spim.xfer(a[7:0], rx);
        for (i = 0; i < n; i = i + 1) begin
            i_sfcc_spim.xfer(d[31 - 8 * i -: 8], rx);
        end
        i_sfcc_spim.desel;
    endtask
    task rdm(input [7:0] op, input [15:0] a, input [31:0] exp, input integer n, input m3);
        integer i;
        i_sfcc_spim.sel(m3);
        i_sfcc_spim.xfer(op, rx);
        i_sfcc_spim.xfer(a[15:8], rx);
        i_sfcc_spim.xfer(a[7:0], rx);
        if (op == 8'h0b) begin
            i_sfcc_spim.xfer(8'h00, rx);
        end
        for (i = 0; i < n; i = i + 1) begin
            i_sfcc_spim.xfer(8'hff, rx);
            chk(rx, exp[31 - 8 * i -: 8]);
        end
        i_sfcc_spim.desel;
        chk({7'h00, so_oe_o}, 8'h00);
    endtask
    task t_latch;
        sread(8'h00);
        i_sfcc_spim.sel(1'b0);
        i_sfcc_spim.xfer(8'h77, rx);
        i_sfcc_spim.xfer(8'h06, rx);
        chk({7'h00, so_oe_o}, 8'h00);
        i_sfcc_spim.desel;
        sread(8'h00);
        i_sfcc_spim.sel(1'b0);
        i_sfcc_spim.xfer(8'h06, rx);
        i_sfcc_spim.xfer(8'h04, rx);
        i_sfcc_spim.desel;
        sread(8'h02);
        op1(8'h04);
        sread(8'h00);
    endtask
    task t_status;
        swr(8'hff, 1'b1);
        sread(8'h8c);
        swr(8'h00, 1'b0);
        sread(8'h8c);
        nrst_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        sread(8'h0c);
        swr(8'h00, 1'b0);
        sread(8'h00);
    endtask
    task t_mem;
        op1(8'h06);
        wrm(16'h3ffe, 32'h11223344, 4);
        op1(8'h06);
        wrm(16'h2fff, 32'h66770000, 2);
        wrm(16'h0001, 32'h99000000, 1);
        swr(8'h04, 1'b0);
        op1(8'h06);
        wrm(16'hefff, 32'ha55a0000, 2);
        rdm(8'h03, 16'h3ffe, 32'h11223344, 4, 1'b0);
        rdm(8'h03, 16'h2fff, 32'ha5770000, 2, 1'b0);
        rdm(8'h0b, 16'h4000, 32'h33440000, 2, 1'b1);
        swr(8'h08, 1'b1);
        op1(8'h06);
        wrm(16'h1fff, 32'hbb770000, 2);
        swr(8'h0c, 1'b1);
        op1(8'h06);
        wrm(16'h0000, 32'hee000000, 1);
        rdm(8'h03, 16'h1fff, 32'hbb000000, 1, 1'b0);
        rdm(8'h03, 16'h0000, 32'h33000000, 1, 1'b0);
    endtask
    initial begin
        repeat (12) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        t_latch;
        t_status;
        t_mem;
        give_verdict;
    end
endmodule // tb_sfcc_core
bind sfcc_core sfcc_core_sva i_sfcc_core_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .status_o(status_o));
